// ### pmf_pkg.sv
// Shared constants and types for the MAC frame assembler.
package pmf_pkg;
  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_NODE = 8'h04;
  localparam logic [7:0] REG_DOM = 8'h08;
  localparam logic [7:0] REG_LEN = 8'h0c;
  localparam logic [7:0] REG_MAXB = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;

  // Configuration word fields.
  localparam int CFG_MULTI = 0;
  localparam int CFG_ACK = 1;
  localparam int CFG_PRIO = 2;
  localparam int CFG_TP = 4;
  localparam int CFG_PAD = 6;
  localparam int CFG_UNITS = 10;
  localparam int CFG_SEGS = 15;
  localparam int CFG_LAST_PAD = 22;
  localparam logic [31:0] CFG_MASK = 32'h0fffffff;
  localparam logic [31:0] CFG_RST = 32'h00000000;

  // Length word fields and node or domain halves.
  localparam int LEN_SEG = 0;
  localparam int LEN_CONT = 16;
  localparam logic [31:0] LEN_MASK = 32'h03ff07ff;
  localparam logic [31:0] LEN_RST = 32'h00000000;
  localparam int ID_SRC = 0;
  localparam int ID_DST = 16;
  localparam logic [31:0] ID_RST = 32'h00000000;
  localparam logic [31:0] MAXB_MASK = 32'h0000ffff;
  localparam logic [31:0] MAXB_RST = 32'h0000ffff;

  // Command and status bits.
  localparam int CMD_START = 0;
  localparam int CMD_NEW_LLC = 1;
  localparam int CMD_CLR_REJ = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REJECT = 1;
  localparam int STAT_SEQ = 8;

  // Header encodings and limits.
  localparam logic [2:0] TYPE_SINGLE = 3'h0;
  localparam logic [2:0] TYPE_MULTI = 3'h1;
  localparam logic [1:0] TP_NONE = 2'h0;
  localparam logic [15:0] NODE_BCAST = 16'hffff;
  localparam logic [10:0] SEG_LEN_MIN = 11'h005;
  localparam logic [10:0] SEG_LEN_MAX = 11'h690;
  localparam logic [10:0] CHECK_LEN = 11'h004;
  localparam logic [10:0] CONT_ROUND = 11'h002;
  localparam logic [7:0] CONT_SAT = 8'hff;
  localparam logic [7:0] PAD_FILL = 8'h00;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  localparam logic RSVD_BIT = 1'b0;
  localparam logic [7:0] SEQ_RST = 8'hff;
  localparam logic [15:0] HDR_BYTES = 16'h0010;
  localparam logic [15:0] FCS_BYTES = 16'h0004;
  localparam logic [3:0] HDR_FIRST = 4'h0;
  localparam logic [3:0] HDR_CRC_END = 4'hc;
  localparam logic [3:0] HDR_CRC_IDX = 4'hf;
  localparam logic [1:0] FCS_LAST = 2'h3;

  // CRC generators and start values.
  localparam logic [7:0] CRC8_POLY = 8'h3f;
  localparam logic [7:0] CRC8_INIT = 8'hff;
  localparam logic [31:0] CRC32_POLY = 32'h1edc6f41;
  localparam logic [31:0] CRC32_INIT = 32'hffff0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_BODY = 3'b011,
    ST_PAD = 3'b010,
    ST_FCS = 3'b110
  } pmf_state_t;
endpackage

// ### pmf_crc.sv
// Byte-serial CRC engine, bits taken least significant first.
`timescale 1ns/1ps
module pmf_crc #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] POLY = '1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic ce_i, // Clock enable.
  input wire logic clear_i, // Restart at the start value.
  input wire logic en_i, // Fold one byte in.
  input wire logic [7:0] data_i, // Byte to fold in.
  output logic [WIDTH-1:0] crc_o // Complemented remainder.
);
  logic [WIDTH-1:0] lfsr;

  // A start value of ones equals complementing the leading coefficients.
  function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] c,
                                            input logic [7:0] d);
    logic [WIDTH-1:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = r[WIDTH-1] ^ d[i];
      r = {r[WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr <= INIT;
    end else if (ce_i) begin
      if (clear_i) begin
        lfsr <= INIT;
      end else if (en_i) begin
        lfsr <= step(lfsr, data_i);
      end
    end
  end

  assign crc_o = ~lfsr;
endmodule

// ### pmf_frame_assembler.sv
// MAC frame assembler: header, segment units, pad and frame check.
`timescale 1ns/1ps
// What this block does
// [RULE1] Units pass through in arrival order
// [RULE2] Single frame drops unit check, adds check
// [RULE3] Multi frame carries one to 16 units
// [RULE4] Frame length never exceeds occupancy limit
// [RULE5] Header goes first, bit 0 leading
// [RULE6] Pad up to 15 bytes after units
// [RULE7] Type field 000 single, 001 multi
// [RULE8] Bit 3 selects acknowledgement granularity
// [RULE9] Segment count field holds total minus one
// [RULE10] Last pad length in bits 15 to 10
// [RULE11] Sequence number increments per link frame
// [RULE12] Node and domain identifiers in octets 3-10
// [RULE13] Contention estimate divided by four, rounded
// [RULE14] Segment length 5 to 1680, above pad
// [RULE15] Two-bit parameter report request field
// [RULE16] Broadcast destination forces request to none
// [RULE17] Request may repeat in next frame
// [RULE18] Access priority in bits 14 to 13
// [RULE19] Reserved header bits driven to zero
// [RULE20] Header CRC-8 in octet 15
// [RULE21] CRC complements leading bits, complements remainder
// [RULE22] Header CRC sent highest coefficient first
// [RULE23] Single frame check is CRC-32 after pad
module pmf_frame_assembler import pmf_pkg::*; (
  input wire logic clk_i, // Clock, 200 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic [7:0] seg_data_i, // Segment unit byte.
  input wire logic seg_valid_i, // Segment byte valid.
  output logic seg_ready_o, // Segment byte accepted when high.
  output logic [7:0] tx_data_o, // Frame byte to the PHY.
  output logic tx_valid_o, // Frame byte valid.
  output logic tx_sof_o, // First byte of a frame.
  output logic tx_eof_o, // Last byte of a frame.
  input wire logic tx_ready_i // PHY takes the byte.
);
  logic [31:0] cfg;
  logic [31:0] node_ids;
  logic [31:0] dom_ids;
  logic [31:0] len_cfg;
  logic [31:0] max_cfg;
  logic [31:0] wmask;
  logic [31:0] rd_data;
  logic [7:0] seq;
  logic reject;
  logic [119:0] hdr;
  pmf_state_t state;
  pmf_state_t next_state;
  logic [3:0] hdr_idx;
  logic [3:0] pad_cnt;
  logic [3:0] pad_last;
  logic [3:0] pad_len;
  logic [10:0] byte_cnt;
  logic [10:0] keep_len;
  logic [10:0] unit_last;
  logic [3:0] unit_cnt;
  logic [3:0] units_m1;
  logic multi;
  logic [1:0] fcs_idx;
  logic wb_req;
  logic wb_write;
  logic start_req;
  logic start_ok;
  logic take;
  logic emit;
  logic emit_sof;
  logic emit_eof;
  logic next_tx_valid;
  logic [7:0] emit_data;
  logic [7:0] crc8;
  logic [31:0] crc32;
  logic [31:0] fcs_shift;
  logic [10:0] seg_len;
  logic [10:0] cont_sum;
  logic [7:0] cont_est;
  logic [3:0] cfg_pad;
  logic [4:0] cfg_units;
  logic [10:0] cfg_keep;
  logic [15:0] frame_bytes;
  logic [15:0] dst_node;
  logic [1:0] rpt_req;
  logic [15:0] hdr_w0;
  logic [15:0] hdr_w12;

  function automatic logic [7:0] bitrev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Byte selects become a bit mask, one lane per select.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
  end

  assign wb_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees the acknowledge.
  assign wb_write = wb_req & wb_we_i & wb_ack_o;
  assign start_req = wb_write & (wb_adr_i == REG_CMD) & wb_sel_i[0]
                     & wb_dat_i[CMD_START];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    if (wb_adr_i == REG_CFG) begin
      rd_data = cfg & CFG_MASK;
    end else if (wb_adr_i == REG_NODE) begin
      rd_data = node_ids;
    end else if (wb_adr_i == REG_DOM) begin
      rd_data = dom_ids;
    end else if (wb_adr_i == REG_LEN) begin
      rd_data = len_cfg & LEN_MASK;
    end else if (wb_adr_i == REG_MAXB) begin
      rd_data = max_cfg & MAXB_MASK;
    end else if (wb_adr_i == REG_CMD) begin
      rd_data[STAT_BUSY] = (state != ST_IDLE);
      rd_data[STAT_REJECT] = reject;
      rd_data[STAT_SEQ +: 8] = seq;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= CFG_RST;
      node_ids <= ID_RST;
      dom_ids <= ID_RST;
      len_cfg <= LEN_RST;
      max_cfg <= MAXB_RST;
    end else if (ce_i && wb_write) begin
      if (wb_adr_i == REG_CFG) begin
        cfg <= (cfg & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == REG_NODE) begin
        node_ids <= (node_ids & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == REG_DOM) begin
        dom_ids <= (dom_ids & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == REG_LEN) begin
        len_cfg <= (len_cfg & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == REG_MAXB) begin
        max_cfg <= (max_cfg & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  assign seg_len = len_cfg[LEN_SEG +: 11];
  assign cfg_pad = cfg[CFG_PAD +: 4]; // see [RULE6]
  // A single frame carries one unit; a multi frame up to sixteen.
  assign cfg_units = cfg[CFG_MULTI] ? {1'b0, cfg[CFG_UNITS +: 4]} + 5'h01
                                    : 5'h01; // see [RULE3]
  assign cfg_keep = cfg[CFG_MULTI] ? seg_len : seg_len - CHECK_LEN;
  // Time on the wire is budgeted in bytes, set by software per rate.
  assign frame_bytes = HDR_BYTES + 16'(cfg_units) * 16'(cfg_keep)
                       + {12'h000, cfg_pad}
                       + (cfg[CFG_MULTI] ? 16'h0000 : FCS_BYTES);
  assign start_ok = start_req & (state == ST_IDLE)
                    & (seg_len >= SEG_LEN_MIN)
                    & (seg_len <= SEG_LEN_MAX) // see [RULE14]
                    & ((cfg_pad == 4'h0) | (seg_len > {7'h00, cfg_pad}))
                    & (frame_bytes <= max_cfg[15:0]); // see [RULE4]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reject <= 1'b0;
    end else if (ce_i) begin
      // A refusal in the clearing cycle still leaves the flag set.
      if (start_req & ~start_ok) begin
        reject <= 1'b1;
      end else if (wb_write & (wb_adr_i == REG_CMD) & wb_sel_i[0]
                   & wb_dat_i[CMD_CLR_REJ]) begin
        reject <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq <= SEQ_RST;
    end else if (ce_i && start_ok && wb_dat_i[CMD_NEW_LLC]) begin
      seq <= seq + 8'h01; // see [RULE11]
    end
  end

  assign cont_sum = {1'b0, len_cfg[LEN_CONT +: 10]} + CONT_ROUND;
  assign cont_est = cont_sum[10] ? CONT_SAT : cont_sum[9:2]; // see [RULE13]
  assign dst_node = node_ids[ID_DST +: 16];
  // Software keeps the last request to repeat it; see [RULE17]
  assign rpt_req = (dst_node == NODE_BCAST) ? TP_NONE
                                            : cfg[CFG_TP +: 2]; // see [RULE16]
  assign hdr_w0 = {cfg[CFG_LAST_PAD +: 6], // see [RULE10]
                   cfg[CFG_SEGS +: 6] - 6'h01, // see [RULE9]
                   cfg[CFG_ACK], // see [RULE8]
                   cfg[CFG_MULTI] ? TYPE_MULTI : TYPE_SINGLE}; // see [RULE7]
  assign hdr_w12 = {RSVD_BIT, cfg[CFG_PRIO +: 2], // see [RULE18]
                    rpt_req, seg_len}; // see [RULE15]

  // Header and frame shape are frozen at start against later writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr <= '0;
      multi <= 1'b0;
      units_m1 <= 4'h0;
      unit_last <= 11'h000;
      keep_len <= 11'h000;
      pad_len <= 4'h0;
      pad_last <= 4'h0;
    end else if (ce_i && start_ok) begin
      hdr <= {RSVD_BYTE, hdr_w12, cont_est, // see [RULE19]
              dom_ids[ID_DST +: 16], dom_ids[ID_SRC +: 16],
              dst_node, node_ids[ID_SRC +: 16], // see [RULE12]
              wb_dat_i[CMD_NEW_LLC] ? seq + 8'h01 : seq, hdr_w0};
      multi <= cfg[CFG_MULTI];
      units_m1 <= cfg_units[3:0] - 4'h1;
      unit_last <= seg_len - 11'h001;
      keep_len <= cfg_keep;
      pad_len <= cfg_pad;
      pad_last <= cfg_pad - 4'h1;
    end
  end

  assign take = ce_i & seg_valid_i & seg_ready_o;
  assign fcs_shift = crc32 << {fcs_idx, 3'b000};

  always_comb begin
    next_state = state;
    emit = 1'b0;
    emit_data = PAD_FILL;
    emit_sof = 1'b0;
    emit_eof = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_HDR;
        end
      end
      ST_HDR: begin
        if (~tx_valid_o | tx_ready_i) begin
          emit = 1'b1;
          emit_sof = (hdr_idx == HDR_FIRST); // see [RULE5]
          emit_data = 8'(hdr >> {hdr_idx, 3'b000});
          if (hdr_idx == HDR_CRC_IDX) begin
            emit_data = bitrev8(crc8); // see [RULE22]
            next_state = ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (take) begin
          // Trailing unit check bytes are swallowed in single frames.
          emit = (byte_cnt < keep_len); // see [RULE2]
          emit_data = seg_data_i; // see [RULE1]
          if (byte_cnt == unit_last && unit_cnt == units_m1) begin
            if (pad_len != 4'h0) begin
              next_state = ST_PAD;
            end else if (multi) begin
              next_state = ST_IDLE;
              emit_eof = 1'b1;
            end else begin
              next_state = ST_FCS;
            end
          end
        end
      end
      ST_PAD: begin
        if (~tx_valid_o | tx_ready_i) begin
          emit = 1'b1; // see [RULE6]
          if (pad_cnt == pad_last) begin
            next_state = multi ? ST_IDLE : ST_FCS;
            emit_eof = multi;
          end
        end
      end
      ST_FCS: begin
        if (~tx_valid_o | tx_ready_i) begin
          emit = 1'b1;
          emit_data = bitrev8(fcs_shift[31:24]); // see [RULE23]
          if (fcs_idx == FCS_LAST) begin
            next_state = ST_IDLE;
            emit_eof = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign next_tx_valid = emit | (tx_valid_o & ~tx_ready_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr_idx <= 4'h0;
      pad_cnt <= 4'h0;
      fcs_idx <= 2'h0;
    end else if (ce_i) begin
      if (start_ok) begin
        hdr_idx <= 4'h0;
        pad_cnt <= 4'h0;
        fcs_idx <= 2'h0;
      end else if (emit && state == ST_HDR) begin
        hdr_idx <= hdr_idx + 4'h1;
      end else if (emit && state == ST_PAD) begin
        pad_cnt <= pad_cnt + 4'h1;
      end else if (emit && state == ST_FCS) begin
        fcs_idx <= fcs_idx + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_cnt <= 11'h000;
      unit_cnt <= 4'h0;
    end else if (ce_i) begin
      if (start_ok) begin
        byte_cnt <= 11'h000;
        unit_cnt <= 4'h0;
      end else if (take) begin
        if (byte_cnt == unit_last) begin
          byte_cnt <= 11'h000;
          unit_cnt <= unit_cnt + 4'h1;
        end else begin
          byte_cnt <= byte_cnt + 11'h001;
        end
      end
    end
  end

  // Ready rises only when the output stage will be empty, so a taken
  // byte always finds room; the price is one idle cycle per byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_ready_o <= 1'b0;
    end else if (ce_i) begin
      seg_ready_o <= (next_state == ST_BODY) & ~take & ~next_tx_valid;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_sof_o <= 1'b0;
      tx_eof_o <= 1'b0;
    end else if (ce_i) begin
      tx_valid_o <= next_tx_valid;
      if (emit) begin
        tx_data_o <= emit_data;
        tx_sof_o <= emit_sof;
        tx_eof_o <= emit_eof;
      end
    end
  end

  pmf_crc #(
    .WIDTH(8),
    .POLY(CRC8_POLY),
    .INIT(CRC8_INIT)
  ) u_hdr_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(start_ok),
    .en_i(emit && state == ST_HDR
          && hdr_idx <= HDR_CRC_END), // see [RULE20] see [RULE21]
    .data_i(emit_data),
    .crc_o(crc8)
  );

  pmf_crc #(
    .WIDTH(32),
    .POLY(CRC32_POLY),
    .INIT(CRC32_INIT)
  ) u_fcs_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(start_ok),
    .en_i(emit && state != ST_FCS), // see [RULE23]
    .data_i(emit_data),
    .crc_o(crc32)
  );
endmodule

// ### pmf_props.sv
// Checker of bus and frame timing at the assembler's ports.
`timescale 1ns/1ps
module pmf_props (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic ce_i, // Enable.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_ack_o, // Ack.
  input wire logic [7:0] seg_data_i, // Unit byte.
  input wire logic seg_valid_i, // Unit valid.
  input wire logic seg_ready_o, // Unit ready.
  input wire logic [7:0] tx_data_o, // Frame byte.
  input wire logic tx_valid_o, // Frame valid.
  input wire logic tx_sof_o, // Frame start.
  input wire logic tx_eof_o, // Frame end.
  input wire logic tx_ready_i // PHY ready.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] idx;
  logic multi;
  logic [15:0] dst;
  logic [7:0] b12;
  wire take = tx_valid_o && tx_ready_i && ce_i;
  // The index saturates at 16, as only header positions are judged here.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx <= 5'h00;
    end else if (take) begin
      idx <= tx_eof_o ? 5'h00 : (idx == 5'h10 ? idx : idx + 5'h01);
    end
  end
  always_ff @(posedge clk_i) begin
    if (take) begin
      multi <= idx == 5'h00 ? tx_data_o[0] : multi;
      dst[7:0] <= idx == 5'h05 ? tx_data_o : dst[7:0];
      dst[15:8] <= idx == 5'h06 ? tx_data_o : dst[15:8];
      b12 <= idx == 5'h0c ? tx_data_o : b12;
    end
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  AST_TX_HOLD: assert property (
    tx_valid_o && !tx_ready_i && ce_i |=> tx_valid_o && $stable(tx_data_o)
    && $stable(tx_sof_o)) else $error("frame byte not held");
  AST_IN_ORDER: assert property (
    seg_valid_i && seg_ready_o && ce_i && multi
    |=> tx_valid_o && tx_data_o == $past(seg_data_i))
    else $error("unit byte not passed on");
  AST_SOF_FIRST: assert property (
    tx_valid_o && tx_sof_o |-> idx == 5'h00) else $error("start misplaced");
  AST_TYPE: assert property (
    tx_valid_o && tx_sof_o |-> tx_data_o[2:1] == 2'h0)
    else $error("bad frame type");
  AST_RSVD13: assert property (
    tx_valid_o && idx == 5'h0d |-> !tx_data_o[7]) else $error("bit set");
  AST_RSVD14: assert property (
    tx_valid_o && idx == 5'h0e |-> tx_data_o == 8'h00)
    else $error("octet 14 set");
  AST_LEN: assert property (
    tx_valid_o && idx == 5'h0d
    |-> {tx_data_o[2:0], b12} inside {[11'h005:11'h690]})
    else $error("unit length out of range");
  AST_BCAST: assert property (
    tx_valid_o && idx == 5'h0d && dst == 16'hffff |-> tx_data_o[4:3] == 2'h0)
    else $error("request on broadcast");
endmodule

// ### pmf_far_end.sv
// Far-side model: segment source upstream and PHY sink downstream.
`timescale 1ns/1ps
module pmf_far_end (
  input wire logic clk_i, // Clock.
  input wire logic slow_i, // PHY stalls.
  input wire logic seg_ready_i, // Unit ready.
  output logic [7:0] seg_data_o, // Unit byte.
  output logic seg_valid_o, // Unit valid.
  input wire logic [7:0] tx_data_i, // Frame byte.
  input wire logic tx_valid_i, // Frame valid.
  input wire logic tx_sof_i, // Frame start.
  input wire logic tx_eof_i, // Frame end.
  output logic tx_ready_o // PHY ready.
);
  logic [7:0] src_q[$];
  logic [9:0] out_q[$];
  logic [1:0] cnt = 2'h0;
  initial begin
    seg_data_o = 8'h00;
    seg_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // An idle data line shows the inverse so a stale byte never looks valid.
  always @(posedge clk_i) begin
    if (seg_valid_o && seg_ready_i) begin
      void'(src_q.pop_front());
    end
    seg_valid_o <= src_q.size() > 0;
    seg_data_o <= src_q.size() > 0 ? src_q[0] : ~seg_data_o;
  end
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    tx_ready_o <= !slow_i || cnt == 2'h0;
    if (tx_valid_i && tx_ready_o) begin
      out_q.push_back({tx_sof_i, tx_eof_i, tx_data_i});
    end
  end
endmodule

// ### plc_mac_frame_assembler_tb_top.sv
// Self-checking bench for the MAC frame assembler.
`timescale 1ns/1ps
module plc_mac_frame_assembler_tb_top import pmf_pkg::*; ;
  typedef struct {logic [31:0] cfg, id, dom, len; logic nf; int n;} pmf_row_t;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, seg_valid_i, seg_ready_o, tx_valid_o, tx_sof_o, tx_eof_o;
  logic tx_ready_i;
  logic [7:0] seg_data_i, tx_data_o, seq = 8'hff;
  int miscompares = 0, checks = 0, cycles = 0;
  pmf_row_t rows[4] = '{
    '{32'h01c280d8, 32'h00421234, 32'h0007beef, 32'h000a0014, 1'b1, 39},
    '{32'h0001043f, 32'hffff0001, 32'h00020003, 32'h03ff0006, 1'b1, 28},
    '{32'h0fc08020, 32'h0005abcd, 32'h00090008, 32'h00020005, 1'b1, 21},
    '{32'h001fbd25, 32'h00100020, 32'h00300040, 32'h00050005, 1'b0, 100}};
  logic [31:0] bad[4][3] = '{'{32'h01c280d8, 32'h00000014, 32'h26},
    '{32'h8000, 32'h4, 32'hffff}, '{32'h8140, 32'h5, 32'hffff},
    '{32'h8000, 32'h691, 32'hffff}};
  always #2.5 clk_i = ~clk_i;
  pmf_frame_assembler u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .seg_data_i(seg_data_i),
    .seg_valid_i(seg_valid_i), .seg_ready_o(seg_ready_o),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_sof_o(tx_sof_o),
    .tx_eof_o(tx_eof_o), .tx_ready_i(tx_ready_i));
  pmf_far_end u_far (.clk_i(clk_i), .slow_i(slow), .seg_ready_i(seg_ready_o),
    .seg_data_o(seg_data_i), .seg_valid_o(seg_valid_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_sof_i(tx_sof_o), .tx_eof_i(tx_eof_o),
    .tx_ready_o(tx_ready_i));
  function automatic logic [31:0] crc(input logic [31:0] c,
    input logic [7:0] d, input int w, input logic [31:0] p);
    for (int i = 0; i < 8; i++) begin
      c = c[w-1] ^ d[i] ? (c << 1) ^ p : c << 1;
    end
    return w == 8 ? c & 32'h000000ff : c;
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the bench timeout ends a wait for the acknowledge.
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic run_row(input pmf_row_t r, input int ri);
    logic [7:0] h[16];
    logic [7:0] e[$];
    logic [31:0] c;
    logic [15:0] w0;
    int u, b, k;
    u = r.cfg[CFG_MULTI] ? int'(r.cfg[13:10]) + 1 : 1;
    b = int'(r.len[10:0]) - (r.cfg[CFG_MULTI] ? 0 : 4);
    for (k = 0; k < u * int'(r.len[10:0]); k++) begin
      u_far.src_q.push_back(8'(k * 7 + ri));
    end
    wb(1'b1, REG_CFG, r.cfg);
    wb(1'b1, REG_NODE, r.id);
    wb(1'b1, REG_DOM, r.dom);
    wb(1'b1, REG_LEN, r.len);
    wb(1'b1, REG_MAXB, 32'(r.n));
    seq = r.nf ? seq + 8'h01 : seq;
    wb(1'b1, REG_CMD, {30'h0, r.nf, 1'b1});
    wb(1'b0, REG_CMD, 32'h0);
    chk(rd[0], 1'b1);
    w0 = {r.cfg[27:22], 6'(r.cfg[20:15] - 6'h01), r.cfg[1],
      r.cfg[0] ? TYPE_MULTI : TYPE_SINGLE};
    {h[1], h[0]} = w0;
    h[2] = seq;
    {h[6], h[5], h[4], h[3]} = r.id;
    {h[10], h[9], h[8], h[7]} = r.dom;
    h[11] = r.len[25:16] > 10'h3fd ? CONT_SAT : 8'((r.len[25:16] + 10'h2) >> 2);
    {h[13], h[12]} = {1'b0, r.cfg[3:2],
      r.id[31:16] == 16'hffff ? 2'h0 : r.cfg[5:4], r.len[10:0]};
    h[14] = 8'h00;
    c = 32'h000000ff;
    for (k = 0; k < 13; k++) c = crc(c, h[k], 8, 32'h0000003f);
    h[15] = rev8(~c[7:0]);
    for (k = 0; k < 16; k++) e.push_back(h[k]);
    for (k = 0; k < u * b; k++) e.push_back(8'(k * 7 + ri));
    for (k = 0; k < int'(r.cfg[9:6]); k++) e.push_back(PAD_FILL);
    if (!r.cfg[0]) begin
      c = 32'hffff0000;
      foreach (e[j]) c = crc(c, e[j], 32, 32'h1edc6f41);
      c = ~c;
      for (k = 0; k < 4; k++) e.push_back(rev8(c[31-8*k -: 8]));
    end
    k = 0;
    while (u_far.out_q.size() < e.size() && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    chk(e.size(), r.n);
    chk(u_far.out_q.size(), e.size());
    foreach (e[j]) begin
      chk(u_far.out_q[j], {j == 0, j == e.size() - 1, e[j]});
    end
    u_far.out_q.delete();
    wb(1'b0, REG_CMD, 32'h0);
    chk(rd[15:8], seq);
  endtask
  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      slow <= i[0];
      run_row(rows[i], i);
    end
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CFG, 32'h0);
    chk(rd, CFG_RST);
    wb_sel_i <= 4'h2;
    wb(1'b1, REG_CFG, 32'hffffffff);
    wb_sel_i <= 4'hf;
    wb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'h0000ff00);
    // A request made while the enable is low must wait for it.
    ce_i <= 1'b0;
    fork
      wb(1'b0, REG_MAXB, 32'h0);
      begin
        repeat (3) @(posedge clk_i);
        chk(wb_ack_o, 1'b0);
        @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    chk(rd, MAXB_RST);
    wb(1'b0, REG_MAXB, 32'h0);
    chk(rd, MAXB_RST);
    wb(1'b0, REG_CMD, 32'h0);
    chk(rd, 32'h0000ff00);
    wb(1'b1, 8'h1c, 32'hffffffff);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    // Each refused start must leave the stream silent and raise the flag.
    foreach (bad[i]) begin
      wb(1'b1, REG_CFG, bad[i][0]);
      wb(1'b1, REG_LEN, bad[i][1]);
      wb(1'b1, REG_MAXB, bad[i][2]);
      wb(1'b1, REG_CMD, 32'h1);
      wb(1'b0, REG_CMD, 32'h0);
      chk(rd[1:0], 2'h2);
      wb(1'b1, REG_CMD, 32'h4);
      wb(1'b0, REG_CMD, 32'h0);
      chk(rd[1:0], 2'h0);
      chk(u_far.out_q.size(), 0);
    end
    seq = 8'hff;
    slow <= 1'b1;
    run_row(rows[2], 2);
    wrap_up();
  end
endmodule
bind pmf_frame_assembler pmf_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .seg_data_i(seg_data_i), .seg_valid_i(seg_valid_i),
  .seg_ready_o(seg_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_sof_o(tx_sof_o), .tx_eof_o(tx_eof_o), .tx_ready_i(tx_ready_i));
